// file: verilog/rscmb_pkg.sv
`default_nettype none
package rscmb_pkg;

  // ===========================================================
  // Register bus
  // ===========================================================
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [ADDR_W-1:0] OFS_CAUSE   = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_EVT_ST  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_EVT_EN  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR = 4'hC;

  // ===========================================================
  // Reset cause and control register layout
  // ===========================================================
  localparam int unsigned BIT_TRAP      = 15;
  localparam int unsigned BIT_ILLOP     = 14;
  localparam int unsigned BIT_DSLP      = 10;
  localparam int unsigned BIT_CFG_MISM  = 9;
  localparam int unsigned BIT_FBIAS     = 8;
  localparam int unsigned BIT_EXT       = 7;
  localparam int unsigned BIT_SOFT_RST  = 6;
  localparam int unsigned BIT_SOFT_WDOG = 5;
  localparam int unsigned BIT_WDOG_TMO  = 4;
  localparam int unsigned BIT_SLEEP     = 3;
  localparam int unsigned BIT_IDLE      = 2;
  localparam int unsigned BIT_BROWNOUT  = 1;
  localparam int unsigned BIT_POR       = 0;

  // Value left by a power-on reset: brown-out and power-on flags set
  localparam logic [DATA_W-1:0] CAUSE_POR_VAL = 16'h0003;
  // Bits that a plain write stores (reserved 13..11 and deep-sleep excluded)
  localparam logic [DATA_W-1:0] CAUSE_WR_MASK = 16'hC3FF;
  // Control bits that take their defined value under master reset
  localparam logic [DATA_W-1:0] CAUSE_CTL_MASK = 16'h0120;
  localparam logic [DATA_W-1:0] CAUSE_CTL_RST  = 16'h0000;

  localparam logic [DATA_W-1:0] EVT_EN_RST = 16'h0000;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 16'h0000;

  // Number of reset request lines into the combiner
  localparam int unsigned NUM_REQ = 9;
  localparam int unsigned SYNC_STAGES = 2;

endpackage : rscmb_pkg
`default_nettype wire

// file: verilog/rscmb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rscmb_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             ref_clk_i,  // Block clock
  input  wire logic             rstn_i,     // Async reset, active low
  input  wire logic [WIDTH-1:0] async_i,    // Levels from pins
  output logic      [WIDTH-1:0] sync_o      // Synchronised levels
);

  // ===========================================================
  // Two-stage synchroniser per line
  // ===========================================================
  logic [WIDTH-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_line
      always_ff @(posedge ref_clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule : rscmb_sync
`default_nettype wire

// file: verilog/rscmb_top.sv
// Function
// RULE1: Master reset is the OR of every active reset request.
// RULE2: Nine causes accepted: power-on, pin, instruction, watchdog, brown-out, mismatch, trap, opcode, wreg.
// RULE3: While master reset is active, control registers are forced to defined values.
// RULE4: Flags have no reset except power-on; other resets leave them intact.
// RULE5: Each reset sets the status flag matching its cause.
// RULE6: Power-on clears the cause register except brown-out and power-on flags, which set.
// RULE7: Software may set or clear any status flag at any time.
// RULE8: A software write to a flag never starts a reset.
// RULE9: Software should clear flags after reading them.
// RULE10: Trap conflict sets the flag at bit 15.
// RULE11: Illegal opcode, address mode or uninitialised wreg sets bit 14.
// RULE12: Configuration mismatch resets and sets bit 9.
// RULE13: Watchdog time-out sets bit 4.
// RULE14: Bit 8 keeps flash bias powered in sleep when 1; else standby.
// RULE15: Bit 5 enables watchdog; fuse enable forces watchdog on regardless.
// RULE16: Sleep with deep-sleep enable sets bit 10; software may only clear it.
// RULE17: Pin reset sets bit 7; reset instruction sets bit 6.
// RULE18: Sleep entry sets bit 3, idle entry sets bit 2; bits 13..11 read zero.
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rscmb_top (
  input  wire logic                          ref_clk_i,         // 10 MHz clock
  input  wire logic                          rstn_i,            // Power-on reset, low
  input  wire logic                          pin_reset_i,       // External pin request
  input  wire logic                          brownout_reset_i,  // Brown-out detector
  input  wire logic                          reset_instr_i,     // Reset instruction
  input  wire logic                          watchdog_tmo_i,    // Watchdog time-out
  input  wire logic                          config_mismatch_i, // Config word mismatch
  input  wire logic                          trap_conflict_i,   // Trap conflict
  input  wire logic                          illegal_op_i,      // Illegal opcode
  input  wire logic                          illegal_amode_i,   // Illegal address mode
  input  wire logic                          uninit_wreg_reset_i, // Uninit wreg pointer
  input  wire logic                          power_save_sleep_i, // Sleep entry pulse
  input  wire logic                          power_save_idle_i,  // Idle entry pulse
  input  wire logic                          deep_sleep_en_i,   // Deep-sleep enable
  input  wire logic                          fuse_watchdog_enable_i, // Fuse bit
  input  wire logic [rscmb_pkg::ADDR_W-1:0]  addr_i,            // Register address
  input  wire logic [rscmb_pkg::DATA_W-1:0]  wr_data_i,         // Write data
  input  wire logic                          wr_i,              // Write strobe
  input  wire logic                          rd_i,              // Read strobe
  output logic      [rscmb_pkg::DATA_W-1:0]  rd_data_o,         // Read data
  output logic                               master_reset_o,    // Master reset, high
  output logic                               watchdog_enable_o, // Watchdog run
  output logic                               flash_bias_keep_o, // Bias on in sleep
  output logic                               irq_o              // Level interrupt
);
  import rscmb_pkg::*;

  // ===========================================================
  // Input synchronisation
  // ===========================================================
  // Pin and brown-out come from outside the clock domain
  logic [1:0] pin_async;
  logic [1:0] pin_sync;
  logic       pin_req;
  logic       brownout_req;

  assign pin_async = {brownout_reset_i, pin_reset_i};

  rscmb_sync #(
    .WIDTH (2)
  ) rscmb_sync_inst (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .async_i   (pin_async),
    .sync_o    (pin_sync)
  );

  assign pin_req      = pin_sync[0];
  assign brownout_req = pin_sync[1];

  // ===========================================================
  // Request collection
  // ===========================================================
  // Power-on is carried by rstn_i itself; the other causes are lines
  logic [NUM_REQ-2:0] req_vec;
  logic               any_req;
  logic               illop_req;

  // Address-mode and uninitialised-pointer faults share the opcode flag
  assign illop_req = illegal_op_i | illegal_amode_i | uninit_wreg_reset_i; // [RULE11]

  assign req_vec = {
    pin_req,
    reset_instr_i,
    watchdog_tmo_i,
    brownout_req,
    config_mismatch_i,
    trap_conflict_i,
    illegal_op_i,
    illegal_amode_i | uninit_wreg_reset_i
  }; // [RULE2]

  assign any_req = |req_vec; // [RULE1]

  // ===========================================================
  // Master reset
  // ===========================================================
  // Held high through power-on, so downstream logic sees one reset
  // Software flag writes never reach any_req [RULE8]
  logic master_reset_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      master_reset_q <= 1'b1;
    end
    else
    begin
      master_reset_q <= any_req; // [RULE1]
    end
  end

  assign master_reset_o = master_reset_q;

  // ===========================================================
  // Register decode
  // ===========================================================
  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction : hit

  // Software view of a cause write: reserved bits never store, and the
  // deep-sleep flag can only be cleared from this side
  function automatic logic [DATA_W-1:0] cause_wr_val(
    input logic [DATA_W-1:0] cur,
    input logic [DATA_W-1:0] wdata
  );
    logic [DATA_W-1:0] v;
    v            = wdata & CAUSE_WR_MASK;
    v[BIT_DSLP]  = cur[BIT_DSLP] & wdata[BIT_DSLP];
    cause_wr_val = v;
  endfunction : cause_wr_val

  // One read multiplexer; the write-only clear register and holes read zero
  // Registers are read, so a flag set in the strobe cycle shows next read
  function automatic logic [DATA_W-1:0] rd_mux(
    input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] cause,
    input logic [DATA_W-1:0] st,
    input logic [DATA_W-1:0] en
  );
    case (a)
      OFS_CAUSE:  rd_mux = cause;
      OFS_EVT_ST: rd_mux = st;
      OFS_EVT_EN: rd_mux = en;
      default:    rd_mux = ZERO_WORD;
    endcase
  endfunction : rd_mux

  logic wr_cause;
  logic wr_evt_en;
  logic wr_evt_clr;

  assign wr_cause   = wr_i & hit(addr_i, OFS_CAUSE);
  assign wr_evt_en  = wr_i & hit(addr_i, OFS_EVT_EN);
  assign wr_evt_clr = wr_i & hit(addr_i, OFS_EVT_CLR);

  // ===========================================================
  // Hardware set events
  // ===========================================================
  logic [DATA_W-1:0] hw_set;

  always_comb
  begin
    hw_set             = ZERO_WORD;
    hw_set[BIT_TRAP]     = trap_conflict_i;                      // [RULE10]
    hw_set[BIT_ILLOP]    = illop_req;                            // [RULE11]
    hw_set[BIT_DSLP]     = power_save_sleep_i & deep_sleep_en_i; // [RULE16]
    hw_set[BIT_CFG_MISM] = config_mismatch_i;                    // [RULE12]
    hw_set[BIT_EXT]      = pin_req;                              // [RULE17]
    hw_set[BIT_SOFT_RST] = reset_instr_i;                        // [RULE17]
    hw_set[BIT_WDOG_TMO] = watchdog_tmo_i;                       // [RULE13]
    hw_set[BIT_SLEEP]    = power_save_sleep_i;                   // [RULE18]
    hw_set[BIT_IDLE]     = power_save_idle_i;                    // [RULE18]
    hw_set[BIT_BROWNOUT] = brownout_req;                         // [RULE5]
  end

  // ===========================================================
  // Reset cause and control register
  // ===========================================================
  logic [DATA_W-1:0] cause_q;
  logic [DATA_W-1:0] cause_d;
  logic [DATA_W-1:0] cause_base;

  always_comb
  begin
    cause_base = cause_q;
    if (wr_cause)
    begin
      cause_base = cause_wr_val(cause_q, wr_data_i); // [RULE7] [RULE16]
    end
    if (power_save_sleep_i | power_save_idle_i)
    begin
      // Power-save entry clears the time-out flag
      cause_base[BIT_WDOG_TMO] = 1'b0;
    end
    if (master_reset_q)
    begin
      // Control bits forced; status flags kept across resets
      cause_base = (cause_base & ~CAUSE_CTL_MASK) | CAUSE_CTL_RST; // [RULE3] [RULE4]
    end
    // Set after clear, so a cause landing with a write is never lost
    cause_d = cause_base | hw_set; // [RULE5]
  end

  // Only power-on restores the whole register
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cause_q <= CAUSE_POR_VAL; // [RULE6]
    end
    else
    begin
      cause_q <= cause_d;
    end
  end

  // ===========================================================
  // Watchdog and flash bias controls
  // ===========================================================
  // Fuse is a static configuration level on this clock
  // Master reset does not mask the fuse term, so a fused watchdog keeps running
  logic wdt_en_q;
  logic fbias_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wdt_en_q <= 1'b0;
    end
    else
    begin
      wdt_en_q <= fuse_watchdog_enable_i | cause_q[BIT_SOFT_WDOG]; // [RULE15]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fbias_q <= 1'b0;
    end
    else
    begin
      // 0 lets the bias drop and the regulator idle in sleep
      fbias_q <= cause_q[BIT_FBIAS]; // [RULE14]
    end
  end

  assign watchdog_enable_o = wdt_en_q;
  assign flash_bias_keep_o = fbias_q;

  // ===========================================================
  // Event interrupt
  // ===========================================================
  // Status has the same layout as the cause register and survives non-power-on resets; the enable clears under master reset
  logic [DATA_W-1:0] evt_st_q;
  logic [DATA_W-1:0] evt_en_q;
  logic [DATA_W-1:0] evt_clr;
  logic              irq_q;

  assign evt_clr = wr_evt_clr ? wr_data_i : ZERO_WORD;

  // A hardware set wins over a clear landing in the same cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      evt_st_q <= ZERO_WORD;
    end
    else
    begin
      evt_st_q <= (evt_st_q & ~evt_clr) | hw_set;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      evt_en_q <= EVT_EN_RST;
    end
    else if (master_reset_q)
    begin
      evt_en_q <= EVT_EN_RST; // [RULE3]
    end
    else if (wr_evt_en)
    begin
      evt_en_q <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(evt_st_q & evt_en_q);
    end
  end

  assign irq_o = irq_q;

  // ===========================================================
  // Read port
  // ===========================================================
  // Data stand only in the cycle after the strobe; clear reads zero
  logic [DATA_W-1:0] rd_data_q;

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_data_q <= ZERO_WORD;
    end
    else if (rd_i)
    begin
      rd_data_q <= rd_mux(addr_i, cause_q, evt_st_q, evt_en_q); // [RULE18]
    end
    else
    begin
      rd_data_q <= ZERO_WORD;
    end
  end

  assign rd_data_o = rd_data_q;

endmodule : rscmb_top
`default_nettype wire

// file: tb/rscmb_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rscmb_top_assertions (
  input wire logic        ref_clk_i,              // Clock
  input wire logic        rstn_i,                 // Reset
  input wire logic        pin_reset_i,            // Pin
  input wire logic        reset_instr_i,          // Instr
  input wire logic        watchdog_tmo_i,         // Wdog
  input wire logic        trap_conflict_i,        // Trap
  input wire logic        fuse_watchdog_enable_i, // Fuse
  input wire logic [3:0]  addr_i,                 // Addr
  input wire logic [15:0] wr_data_i,              // Wdata
  input wire logic        wr_i,                   // Write
  input wire logic        rd_i,                   // Read
  input wire logic [15:0] rd_data_o,              // Rdata
  input wire logic        master_reset_o,         // Reset out
  input wire logic        watchdog_enable_o,      // Wdog run
  input wire logic        flash_bias_keep_o,      // Bias
  input wire logic        irq_o                   // Irq
);
  import rscmb_pkg::*;
  logic sreq;
  logic cwr;
  assign sreq = reset_instr_i | watchdog_tmo_i | trap_conflict_i;
  assign cwr  = wr_i && addr_i == OFS_CAUSE && !master_reset_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // Sequences
  // ==========================================================
  sequence pin_held;
    pin_reset_i [*3];
  endsequence
  sequence cause_rd;
    rd_i && addr_i == OFS_CAUSE;
  endsequence
  req_reset_a: assert property (sreq |=> master_reset_o)
    else $error("request did not raise master reset");
  pin_delay_a: assert property (pin_held |=> master_reset_o)
    else $error("pin request did not raise master reset");
  fuse_wdog_a: assert property (fuse_watchdog_enable_i |=> watchdog_enable_o)
    else $error("fuse did not force watchdog on");
  soft_wdog_a: assert property (cwr && wr_data_i[BIT_SOFT_WDOG]
    |-> ##2 (watchdog_enable_o || master_reset_o)) else $error("soft enable lost");
  bias_write_a: assert property (cwr && wr_data_i[BIT_FBIAS]
    |-> ##2 (flash_bias_keep_o || master_reset_o)) else $error("bias bit lost");
  ctl_forced_a: assert property (master_reset_o [*3] |=> !irq_o && !flash_bias_keep_o)
    else $error("control not forced under reset");
  rd_idle_a: assert property (!$past(rd_i) |-> rd_data_o == ZERO_WORD)
    else $error("read data outside read slot");
  reserved_zero_a: assert property (cause_rd |=> rd_data_o[13:11] == 3'h0)
    else $error("reserved bits not zero");
  unmapped_zero_a: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rd_data_o == ZERO_WORD)
    else $error("unmapped read not zero");
endmodule : rscmb_top_assertions
bind rscmb_top rscmb_top_assertions rscmb_top_assertions_inst (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .pin_reset_i(pin_reset_i),
  .reset_instr_i(reset_instr_i), .watchdog_tmo_i(watchdog_tmo_i),
  .trap_conflict_i(trap_conflict_i), .fuse_watchdog_enable_i(fuse_watchdog_enable_i),
  .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
  .rd_data_o(rd_data_o), .master_reset_o(master_reset_o),
  .watchdog_enable_o(watchdog_enable_o), .flash_bias_keep_o(flash_bias_keep_o),
  .irq_o(irq_o)
);
`default_nettype wire

// file: tb/rscmb_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module rscmb_src_model (
  input  wire logic       ref_clk_i, // Clock
  input  wire logic       rstn_i,    // Reset
  input  wire logic [8:0] fire_i,    // Start one source
  output logic      [8:0] req_o      // Held requests
);
  logic [2:0] cnt_q;
  // Held six cycles so the pin synchroniser sees it
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      req_o <= 9'h000;
      cnt_q <= 3'h0;
    end
    else if (|fire_i)
    begin
      req_o <= fire_i;
      cnt_q <= 3'h5;
    end
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
    else
      req_o <= 9'h000;
  end
endmodule : rscmb_src_model
`default_nettype wire

// file: tb/rscmb_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module rscmb_top_test;
  import rscmb_pkg::*;
  logic        ref_clk_i, rstn_i, wr_i, rd_i, rd_seen;
  logic        power_save_sleep_i, power_save_idle_i, deep_sleep_en_i, fuse_watchdog_enable_i;
  logic        master_reset_o, watchdog_enable_o, flash_bias_keep_o, irq_o;
  logic [3:0]  addr_i;
  logic [15:0] wr_data_i, rd_data_o, r;
  logic [8:0]  fire, req;
  logic [15:0] exp_q[$];
  int          miscompares, compares;
  int unsigned flag_bit [9] = '{BIT_EXT, BIT_BROWNOUT, BIT_SOFT_RST,
    BIT_WDOG_TMO, BIT_CFG_MISM, BIT_TRAP,
    BIT_ILLOP, BIT_ILLOP, BIT_ILLOP};
  rscmb_src_model rscmb_src_model_inst (.ref_clk_i, .rstn_i, .fire_i(fire), .req_o(req));
  rscmb_top rscmb_top_inst (.ref_clk_i, .rstn_i, .pin_reset_i(req[0]),
    .brownout_reset_i(req[1]), .reset_instr_i(req[2]), .watchdog_tmo_i(req[3]),
    .config_mismatch_i(req[4]), .trap_conflict_i(req[5]), .illegal_op_i(req[6]),
    .illegal_amode_i(req[7]), .uninit_wreg_reset_i(req[8]), .power_save_sleep_i,
    .power_save_idle_i, .deep_sleep_en_i, .fuse_watchdog_enable_i, .addr_i, .wr_data_i,
    .wr_i, .rd_i, .rd_data_o, .master_reset_o, .watchdog_enable_o, .flash_bias_keep_o,
    .irq_o);
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic give_verdict();
    if (miscompares == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic we, input logic [3:0] a, input logic [15:0] d);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= we;
    rd_i      <= !we;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, ZERO_WORD);
  endtask : rd
  // Bounded wait on master reset (sel 0) or interrupt
  task automatic wait_out(input int sel, input logic v);
    int n = 0;
    while (((sel == 0) ? master_reset_o : irq_o) !== v)
    begin
      @(posedge ref_clk_i);
      n++;
      if (n == 40)
      begin
        miscompares++;
        give_verdict();
      end
    end
  endtask : wait_out
  task automatic hit(input int i);
    fire <= 9'h001 << i;
    @(posedge ref_clk_i);
    fire <= 9'h000;
    wait_out(0, 1'b1);
    wait_out(0, 1'b0);
  endtask : hit
  task automatic pwr(input logic s, input logic dp);
    deep_sleep_en_i    <= dp;
    power_save_sleep_i <= s;
    power_save_idle_i  <= !s;
    @(posedge ref_clk_i);
    power_save_sleep_i <= 1'b0;
    power_save_idle_i  <= 1'b0;
    @(posedge ref_clk_i);
  endtask : pwr
  always @(posedge ref_clk_i) rd_seen <= rd_i;
  // Read data stands only in the cycle after the strobe
  always @(negedge ref_clk_i)
    if (rd_seen === 1'b1)
      chk(rd_data_o, exp_q.pop_front());
  initial
  begin
    {rstn_i, wr_i, rd_i, power_save_sleep_i, power_save_idle_i} = 5'h00;
    {deep_sleep_en_i, fuse_watchdog_enable_i, addr_i, wr_data_i, fire} = 31'h0;
    miscompares = 0;
    compares = 0;
    r = 16'($urandom(32'hD154));
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CAUSE, CAUSE_POR_VAL);
    rd(OFS_EVT_EN, EVT_EN_RST);
    rd(OFS_EVT_CLR, ZERO_WORD);
    rd(4'h2, ZERO_WORD);
    repeat (4)
    begin
      r = 16'($urandom);
      bus(1'b1, OFS_CAUSE, r);
      rd(OFS_CAUSE, r & CAUSE_WR_MASK);
      chk({13'h0, master_reset_o, flash_bias_keep_o, watchdog_enable_o}, {14'h0, r[8], r[5]});
    end
    fuse_watchdog_enable_i <= 1'b1;
    bus(1'b1, OFS_CAUSE, 16'h0010);
    rd(OFS_CAUSE, 16'h0010);
    chk({15'h0, watchdog_enable_o}, 16'h0001);
    fuse_watchdog_enable_i <= 1'b0;
    pwr(1'b1, 1'b1);
    rd(OFS_CAUSE, 16'h0408);
    bus(1'b1, OFS_CAUSE, ZERO_WORD);
    bus(1'b1, OFS_CAUSE, 16'h0400);
    pwr(1'b0, 1'b0);
    rd(OFS_CAUSE, 16'h0004);
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b1, OFS_CAUSE, 16'h0121);
      hit(i);
      rd(OFS_CAUSE, (16'h0001 << flag_bit[i]) | 16'h0001);
      chk({14'h0, flash_bias_keep_o, watchdog_enable_o}, 16'h0000);
    end
    bus(1'b1, OFS_EVT_CLR, 16'hFFFF);
    rd(OFS_EVT_ST, ZERO_WORD);
    bus(1'b1, OFS_EVT_EN, 16'h0010);
    hit(3);
    rd(OFS_EVT_EN, ZERO_WORD);
    bus(1'b1, OFS_EVT_EN, 16'h0010);
    wait_out(1, 1'b1);
    bus(1'b1, OFS_EVT_EN, ZERO_WORD);
    wait_out(1, 1'b0);
    bus(1'b1, OFS_EVT_EN, 16'h0010);
    wait_out(1, 1'b1);
    bus(1'b1, OFS_EVT_CLR, 16'h0010);
    wait_out(1, 1'b0);
    rstn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    rd(OFS_CAUSE, CAUSE_POR_VAL);
    give_verdict();
  end
endmodule : rscmb_top_test
`default_nettype wire
